//--- core/wid_pkg.sv
// Package: constants and types of the aspect and ID control block
`default_nettype none
package wid_pkg;
    // ==========================================
    // Serial bus
    localparam logic [6:0] SLAVE_ADDR = 7'h1C;     // Own 7-bit bus address
    localparam logic [3:0] BITS_BYTE = 4'h8;       // Bits per byte
    localparam logic [1:0] WRITE_BYTES = 2'h2;     // Setting bytes accepted
    // ==========================================
    // Reset values and forced values
    localparam logic [7:0] CFG1_RESET = 8'h14;     // Standard check levels
    localparam logic [7:0] CFG2_RESET = 8'h00;     // 525/60, no reset bits
    localparam logic [1:0] LOWF_LEVEL_FIX = 2'h1;  // Low-frequency level 01
    localparam logic [1:0] LUMA_LEVEL_LO = 2'h1;   // Clock pin low: 01
    localparam logic [1:0] LUMA_LEVEL_HI = 2'h2;   // Clock pin high: 10
    // ==========================================
    // Aspect transition wait
    localparam int CLK_MHZ = 100;                  // Core clock rate
    localparam int WAIT_MS = 1000;                 // Least wait, 1 s
    localparam int WAIT_CYC = WAIT_MS * 1000 * CLK_MHZ; // Wait in cycles
    localparam int WAIT_W = 27;                    // Wait counter width
    // ==========================================
    // Aspect codes
    localparam logic [1:0] ASP_NORMAL = 2'h0;      // 4:3 picture
    localparam logic [1:0] ASP_WIDE = 2'h1;        // 16:9 picture
    localparam logic [1:0] ASP_SUBT = 2'h2;        // Wide with subtitles
    // ==========================================
    // Types
    typedef enum logic [2:0] {
        BUS_IDLE, BUS_ADDR, BUS_AACK, BUS_WDATA, BUS_WACK, BUS_RDATA, BUS_RACK
    } wid_bus_e;                                   // Serial slave states
    typedef struct packed {
        logic subcarrierCheckDisable;              // Amplitude check off
        logic secondIdDecoderReset;                // Second decoder reset
        logic [1:0] lowFreqCheckLevel;             // Low-frequency level
        logic [1:0] lumaCheckLevel;                // Luminance level
        logic singleLineWindow;                    // One line only
        logic firstIdDecoderReset;                 // First decoder reset
        logic aspectReset;                         // Aspect reset to 4:3
        logic instantSwitch;                       // Skip the wait
        logic [3:0] testBits;                      // Test bits
        logic upperAreaSelect;                     // Upper area select
        logic lineStandardSelect;                  // 0 = 525/60
    } wid_cfg_s;
    typedef struct packed {
        logic [1:0] secondIdBits;                  // Second ID bits 3, 5
        logic secondIdValid;                       // Second ID valid
        logic [1:0] firstIdBits;                   // Full mode, letterbox
        logic firstIdValid;                        // First ID valid
        logic [1:0] aspectResult;                  // Aspect decision
    } wid_status_s;
    typedef struct packed {
        logic [1:0] busSync;                       // Mode select sync
        logic [1:0] sclSync;                       // Clock pin sync
        logic [1:0] sdaSync;                       // Data pin sync
        logic sclPrev;                             // Clock for edges
        logic sdaPrev;                             // Data for edges
        wid_bus_e bus;                             // Slave state
        logic [3:0] bitCnt;                        // Bit count
        logic [7:0] shift;                         // Shift register
        logic readMode;                            // Read transfer
        logic [1:0] byteIdx;                       // Written byte index
        logic drvLow;                              // Pull data low
        logic [7:0] cfg1;                          // First setting byte
        logic [7:0] cfg2;                          // Second setting byte
        wid_cfg_s cfg;                             // Settings in force
        logic instPrev;                            // Instant bit delayed
        logic noWait;                              // Wait skipped
        logic [WAIT_W-1:0] waitCnt;                // Wait counter
        logic [1:0] aspect;                        // Aspect output
        logic [4:0] pins;                          // Direct pins
    } wid_state_s;
endpackage
`default_nettype wire

//--- core/wid_control_regs.sv
// Module: serial settings, status byte, bus-free mode and direct pins
// How it works
// - Status bit 2 is first ID valid
// - Status bits 1:0 give aspect code
// - Mode select low: no bus, pins are settings
// - Bus-free forces other settings to fixed values
// - Bus-free check disable follows data pin
// - Bus-free luma level follows clock pin
// - ID pins are result AND valid, wide pins decode aspect output
// - Status byte keeps results and valids apart
// - Setting pairs give ghost and weak strengths
// - Check disable stops subcarrier amplitude check
// - Luma field sets confirmation threshold
// - Instant bit rise shows current judgement
// - No-wait ends on change or bit low
// - Aspect output waits before following judgement
// - Two bytes written, one byte read
// - Serial bus active only in bus mode
`default_nettype none
module wid_control_regs #(
    parameter int WAIT_CYCLES = wid_pkg::WAIT_CYC  // Aspect wait in cycles
) (
    input wire logic clk,                          // 100 MHz clock
    input wire logic reset,                        // Async reset, high
    input wire logic busModeSelect,                // Pin: 1 = bus mode
    input wire logic sclIn,                        // Pin: serial clock
    input wire logic sdaIn,                        // Pin: serial data in
    output logic sdaOut,                           // Serial data out, 0
    output logic sdaOe,                            // Pull data line low
    input wire logic [1:0] firstIdBits,            // First ID result
    input wire logic firstIdValid,                 // First ID valid
    input wire logic [1:0] secondIdBits,           // Second ID result
    input wire logic secondIdValid,                // Second ID valid
    input wire logic [1:0] aspectJudge,            // Judgement in progress
    output wid_pkg::wid_cfg_s settings,            // Settings to decoders
    output logic [1:0] aspectResult,               // Aspect output code
    output logic letterboxOut,                     // Letterbox pin
    output logic fullModeOut,                      // Full mode pin
    output logic secondIdOut,                      // Second ID bit pin
    output logic widePlainOut,                     // Wide, no subtitles
    output logic wideSubtitleOut                   // Wide with subtitles
);
    // ==========================================
    // State
    wid_pkg::wid_state_s st;                       // Registered state
    wid_pkg::wid_state_s next_st;                  // Next state
    wid_pkg::wid_status_s status;                  // Status byte fields
    logic busOn;                                   // Bus mode, synced
    logic sclRise;                                 // Clock rising
    logic sclFall;                                 // Clock falling
    logic startSeen;                               // Start condition
    logic stopSeen;                                // Stop condition
    localparam logic [wid_pkg::WAIT_W-1:0] WAIT_LAST =
        wid_pkg::WAIT_W'(WAIT_CYCLES - 1);         // Last wait count

    // ==========================================
    // Edge and condition detect on synced pins
    assign busOn = st.busSync[1];
    assign sclRise = st.sclSync[1] & ~st.sclPrev;
    assign sclFall = ~st.sclSync[1] & st.sclPrev;
    assign startSeen = st.sclSync[1] & st.sclPrev & st.sdaPrev & ~st.sdaSync[1];
    assign stopSeen = st.sclSync[1] & st.sclPrev & ~st.sdaPrev & st.sdaSync[1];

    // Status byte from live results, kept apart
    always_comb begin
        status.secondIdBits = secondIdBits;
        status.secondIdValid = secondIdValid;
        status.firstIdBits = firstIdBits;
        status.firstIdValid = firstIdValid;
        status.aspectResult = st.aspect;
    end

    // ==========================================
    // Next-state logic
    always_comb begin
        next_st = st;
        // Two-stage pin synchronisers
        next_st.busSync = {st.busSync[0], busModeSelect};
        next_st.sclSync = {st.sclSync[0], sclIn};
        next_st.sdaSync = {st.sdaSync[0], sdaIn};
        next_st.sclPrev = st.sclSync[1];
        next_st.sdaPrev = st.sdaSync[1];
        // Serial slave
        if (!busOn) begin
            // Bus ignored in bus-free mode
            next_st.bus = wid_pkg::BUS_IDLE;
            next_st.drvLow = 1'b0;
        end else if (startSeen) begin
            // Start or repeated start
            next_st.bus = wid_pkg::BUS_ADDR;
            next_st.bitCnt = '0;
            next_st.byteIdx = '0;
            next_st.drvLow = 1'b0;
        end else if (stopSeen) begin
            next_st.bus = wid_pkg::BUS_IDLE;
            next_st.drvLow = 1'b0;
        end else begin
            unique case (st.bus)
                wid_pkg::BUS_IDLE: begin
                    next_st.drvLow = 1'b0;
                end
                wid_pkg::BUS_ADDR, wid_pkg::BUS_WDATA: begin
                    // Shift in on rise, decide after eighth bit
                    if (sclRise) begin
                        next_st.shift = {st.shift[6:0], st.sdaSync[1]};
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end else if (sclFall && st.bitCnt == wid_pkg::BITS_BYTE) begin
                        next_st.bitCnt = '0;
                        if (st.bus == wid_pkg::BUS_ADDR) begin
                            if (st.shift[7:1] == wid_pkg::SLAVE_ADDR) begin
                                next_st.readMode = st.shift[0];
                                next_st.drvLow = 1'b1;
                                next_st.bus = wid_pkg::BUS_AACK;
                            end else begin
                                next_st.bus = wid_pkg::BUS_IDLE;
                            end
                        end else if (st.byteIdx < wid_pkg::WRITE_BYTES) begin
                            // Store setting byte and acknowledge
                            if (st.byteIdx == 2'h0) begin
                                next_st.cfg1 = st.shift;
                            end else begin
                                next_st.cfg2 = st.shift;
                            end
                            next_st.byteIdx = st.byteIdx + 2'h1;
                            next_st.drvLow = 1'b1;
                            next_st.bus = wid_pkg::BUS_WACK;
                        end else begin
                            // Extra byte: no acknowledge
                            next_st.bus = wid_pkg::BUS_IDLE;
                        end
                    end
                end
                wid_pkg::BUS_AACK, wid_pkg::BUS_WACK: begin
                    // After acknowledge clock: release, or put out status bit 7 in a read
                    if (sclFall) begin
                        next_st.bitCnt = '0;
                        if (st.bus == wid_pkg::BUS_AACK && st.readMode) begin
                            next_st.shift = status;
                            next_st.drvLow = ~status[7];
                            next_st.bus = wid_pkg::BUS_RDATA;
                        end else begin
                            next_st.drvLow = 1'b0;
                            next_st.bus = wid_pkg::BUS_WDATA;
                        end
                    end
                end
                wid_pkg::BUS_RDATA: begin
                    // Next bit on each fall, release after eight
                    if (sclFall) begin
                        next_st.bitCnt = st.bitCnt + 4'h1;
                        next_st.shift = {st.shift[6:0], 1'b0};
                        if (st.bitCnt == wid_pkg::BITS_BYTE - 4'h1) begin
                            next_st.drvLow = 1'b0;
                            next_st.bus = wid_pkg::BUS_RACK;
                        end else begin
                            next_st.drvLow = ~st.shift[6];
                        end
                    end
                end
                wid_pkg::BUS_RACK: begin
                    // One status byte only, then wait for stop
                    if (sclRise) begin
                        next_st.bus = wid_pkg::BUS_IDLE;
                    end
                end
                default: begin
                    next_st.bus = wid_pkg::BUS_IDLE;
                end
            endcase
        end
        // Settings in force
        if (busOn) begin
            next_st.cfg = {st.cfg1, st.cfg2};
        end else begin
            next_st.cfg = '0;
            next_st.cfg.lowFreqCheckLevel = wid_pkg::LOWF_LEVEL_FIX;
            next_st.cfg.subcarrierCheckDisable = st.sdaSync[1];
            next_st.cfg.lumaCheckLevel = st.sclSync[1] ?
                wid_pkg::LUMA_LEVEL_HI : wid_pkg::LUMA_LEVEL_LO;
        end
        // Aspect output with transition wait
        next_st.instPrev = st.cfg.instantSwitch;
        if (st.cfg.aspectReset) begin
            next_st.aspect = wid_pkg::ASP_NORMAL;
            next_st.waitCnt = '0;
            next_st.noWait = 1'b0;
        end else begin
            if (st.cfg.instantSwitch && !st.instPrev) begin
                next_st.noWait = 1'b1;
            end else if (!st.cfg.instantSwitch) begin
                next_st.noWait = 1'b0;
            end
            if (aspectJudge == st.aspect) begin
                next_st.waitCnt = '0;
            end else if (next_st.noWait || st.waitCnt == WAIT_LAST) begin
                next_st.aspect = aspectJudge;
                next_st.waitCnt = '0;
                next_st.noWait = 1'b0;
            end else begin
                next_st.waitCnt = st.waitCnt + 1'b1;
            end
        end
        // Direct pins: ID result AND valid, wide pins from aspect output
        next_st.pins = {firstIdBits[0] & firstIdValid,
                        firstIdBits[1] & firstIdValid,
                        secondIdBits[1] & secondIdValid,
                        st.aspect == wid_pkg::ASP_WIDE,
                        st.aspect == wid_pkg::ASP_SUBT};
    end

    // ==========================================
    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.sclSync <= 2'h3;
            st.sdaSync <= 2'h3;
            st.sclPrev <= 1'b1;
            st.sdaPrev <= 1'b1;
            st.cfg1 <= wid_pkg::CFG1_RESET;
            st.cfg2 <= wid_pkg::CFG2_RESET;
            st.bus <= wid_pkg::BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================
    // Outputs
    assign sdaOut = 1'b0;
    assign sdaOe = st.drvLow;
    assign settings = st.cfg;
    assign aspectResult = st.aspect;
    assign {letterboxOut, fullModeOut, secondIdOut, widePlainOut, wideSubtitleOut} = st.pins;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence instRise;
        !st.cfg.instantSwitch ##1 st.cfg.instantSwitch && !st.cfg.aspectReset;
    endsequence
    pin_and_a: assert property (##1 letterboxOut == $past(firstIdBits[0] & firstIdValid))
        else $error("letterbox pin not result AND valid");
    status_map_a: assert property (status[2] == firstIdValid && status[1:0] == st.aspect)
        else $error("status valid or aspect bits wrong");
    status_apart_a: assert property (status[7:3] == {secondIdBits, secondIdValid, firstIdBits})
        else $error("status results not kept apart");
    free_forced_a: assert property (!busOn ##1 !busOn |-> settings.lowFreqCheckLevel == 2'h1
        && {settings.secondIdDecoderReset, settings.firstIdDecoderReset, settings.singleLineWindow,
        settings.aspectReset, settings.instantSwitch, settings.testBits, settings.upperAreaSelect,
        settings.lineStandardSelect} == 11'h000)
        else $error("bus-free settings not forced");
    free_sda_a: assert property (!busOn |=> settings.subcarrierCheckDisable == $past(st.sdaSync[1]))
        else $error("check disable not from data pin");
    free_scl_a: assert property (!busOn |=> settings.lumaCheckLevel == ($past(st.sclSync[1]) ? 2'h2 : 2'h1))
        else $error("luma level not from clock pin");
    no_drive_a: assert property (!busOn |=> !sdaOe)
        else $error("data pin driven in bus-free mode");
    instant_a: assert property (instRise ##0 aspectJudge != st.aspect |=> st.aspect == $past(aspectJudge))
        else $error("instant switch did not follow judgement");
    nowait_end_a: assert property (st.noWait && !st.cfg.instantSwitch |=> !st.noWait)
        else $error("no-wait not ended by bit low");
    hold_wait_a: assert property ($changed(st.aspect) |-> $past(st.noWait || st.cfg.instantSwitch
        || st.waitCnt == WAIT_LAST || st.cfg.aspectReset))
        else $error("aspect changed before wait ended");
endmodule
`default_nettype wire

//--- dv/wid_host_model.sv
// Host model: two-wire bus master that also sets the pins in bus-free mode
`default_nettype none
module wid_host_model (
    input wire logic clk,   // Core clock, paces the link
    input wire logic sdaOe, // Block pulls data low
    output logic sclLine,   // Clock pin level
    output logic sdaLine    // Data pin level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic sdaDrv; // Master data, 1 = released
    // ==========================================
    // Open drain with pull-up: any low wins
    assign sdaLine = sdaDrv & ~sdaOe;
    // Idle bus: both lines high, link clock still
    initial begin
        sclLine = 1'b1;
        sdaDrv = 1'b1;
    end
    // Wait cycles, then step just past the edge
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Bus-free use: pins as static settings
    task automatic setPins(input logic scl, input logic sda);
        sclLine = scl;
        sdaDrv = sda;
    endtask
    // One link clock of 16 core cycles, data sampled mid-high
    task automatic bitOut(input logic b, output logic seen);
        sdaDrv = b;
        w(4);
        sclLine = 1'b1;
        w(4);
        seen = sdaLine;
        w(4);
        sclLine = 1'b0;
        w(4);
    endtask
    // Byte out MSB first, then the acknowledge slot
    task automatic byteOut(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(b[i], s);
        end
        bitOut(1'b1, s);
        ack = ~s;
    endtask
    // Start and stop conditions
    task automatic startCond();
        setPins(1'b1, 1'b1);
        w(8);
        sdaDrv = 1'b0;
        w(8);
        sclLine = 1'b0;
        w(4);
    endtask
    task automatic stopCond();
        sdaDrv = 1'b0;
        w(4);
        sclLine = 1'b1;
        w(8);
        sdaDrv = 1'b1;
        w(8);
    endtask
    // Write frame: address then n setting bytes from the top of data
    task automatic writeFrame(input logic [7:0] addr, input logic [23:0] data, input int n,
                              output logic [3:0] acks);
        acks = 4'h0;
        startCond();
        byteOut(addr, acks[0]);
        for (int i = 0; i < n; i++) begin
            byteOut(data[23-8*i -: 8], acks[i+1]);
        end
        stopCond();
    endtask
    // Read frame: exactly one status byte, then no acknowledge
    task automatic readFrame(input logic [7:0] addr, output logic ack, output logic [7:0] v);
        logic s;
        startCond();
        byteOut(addr, ack);
        for (int i = 7; i >= 0; i--) begin
            bitOut(1'b1, v[i]);
        end
        bitOut(1'b1, s);
        stopCond();
    endtask
endmodule
`default_nettype wire

//--- dv/test_wid_control_regs.sv
// Testbench: settings, status byte, bus-free mode, direct pins and aspect wait
`default_nettype none
module test_wid_control_regs;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int WAITN = 1000; // Aspect wait, longer than one write frame
    logic clk = 1'b0; // Core clock
    logic reset; // Async reset
    logic busModeSelect; // Mode pin
    logic [1:0] firstIdBits; // First ID result
    logic firstIdValid; // First ID valid
    logic [1:0] secondIdBits; // Second ID result
    logic secondIdValid; // Second ID valid
    logic [1:0] aspectJudge; // Judgement in progress
    logic sclLine, sdaLine, sdaOe, sdaOut; // Link lines
    wid_pkg::wid_cfg_s settings; // Settings in force
    logic [1:0] aspectResult; // Aspect output
    logic letterboxOut, fullModeOut, secondIdOut, widePlainOut, wideSubtitleOut; // Pins
    logic [3:0] acks; // Acknowledges seen
    logic ack; // Read acknowledge
    logic [7:0] st; // Status byte
    int n_mismatch = 0;
    int cmp_count = 0;
    // ==========================================
    // Clock and instances
    always #5 clk = ~clk;
    wid_host_model host (.clk(clk), .sdaOe(sdaOe), .sclLine(sclLine), .sdaLine(sdaLine));
    wid_control_regs #(.WAIT_CYCLES(WAITN)) dut (
        .clk(clk), .reset(reset), .busModeSelect(busModeSelect), .sclIn(sclLine),
        .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .firstIdBits(firstIdBits),
        .firstIdValid(firstIdValid), .secondIdBits(secondIdBits), .secondIdValid(secondIdValid),
        .aspectJudge(aspectJudge), .settings(settings), .aspectResult(aspectResult),
        .letterboxOut(letterboxOut), .fullModeOut(fullModeOut), .secondIdOut(secondIdOut),
        .widePlainOut(widePlainOut), .wideSubtitleOut(wideSubtitleOut));
    // ==========================================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Bus-free settings for given pin levels
    function automatic logic [15:0] freeExp(input logic scl, input logic sda);
        return {sda, 1'b0, wid_pkg::LOWF_LEVEL_FIX,
                scl ? wid_pkg::LUMA_LEVEL_HI : wid_pkg::LUMA_LEVEL_LO, 10'h000};
    endfunction
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        reset = 1'b1;
        busModeSelect = 1'b0;
        firstIdBits = 2'h0;
        firstIdValid = 1'b0;
        secondIdBits = 2'h0;
        secondIdValid = 1'b0;
        aspectJudge = 2'h0;
        step(10);
        check("reset settings", 16'h0000, settings);
        reset = 1'b0;
        // Bus-free: pins become settings, the rest fixed
        for (int i = 0; i < 4; i++) begin
            host.setPins(i[1], i[0]);
            step(5);
            check("free settings", freeExp(i[1], i[0]), settings);
        end
        host.writeFrame(8'h38, 24'h14_0000, 2, acks);
        check("free acks", 16'h0000, {12'h000, acks});
        check("free idle settings", freeExp(1'b1, 1'b1), settings);
        $display("Test bus-free done");
        // Direct pins are result AND valid
        for (int i = 0; i < 8; i++) begin
            firstIdBits = i[1:0];
            firstIdValid = i[2];
            secondIdBits = i[1:0];
            secondIdValid = i[2];
            step(2);
            check("direct pins", {13'h0000, i[0] & i[2], i[1] & i[2], i[1] & i[2]},
                  {13'h0000, letterboxOut, fullModeOut, secondIdOut});
        end
        $display("Test direct pins done");
        // Bus mode writes and reads
        busModeSelect = 1'b1;
        step(5);
        host.writeFrame(8'h38, 24'h94_0300, 3, acks);
        check("write acks", 16'h0007, {12'h000, acks});
        check("bus settings", 16'h9403, settings);
        host.writeFrame(8'h3A, 24'h14_0000, 2, acks);
        check("foreign acks", 16'h0000, {12'h000, acks});
        check("kept settings", 16'h9403, settings);
        host.writeFrame(8'h38, 24'h14_0000, 2, acks);
        check("std settings", 16'h1400, settings);
        firstIdBits = 2'h2;
        firstIdValid = 1'b0;
        secondIdBits = 2'h1;
        secondIdValid = 1'b1;
        host.readFrame(8'h39, ack, st);
        check("read ack", 16'h0001, {15'h0000, ack});
        check("status", 16'h0070, {8'h00, st});
        check("data out level", 16'h0000, {15'h0000, sdaOut});
        $display("Test bus done");
        // Aspect wait, codes and pins
        aspectJudge = 2'h1;
        step(10);
        check("aspect held", 16'h0000, {12'h000, aspectResult, widePlainOut, wideSubtitleOut});
        step(WAITN + 5);
        check("aspect wide", 16'h0006, {12'h000, aspectResult, widePlainOut, wideSubtitleOut});
        aspectJudge = 2'h2;
        step(WAITN + 10);
        check("aspect subt", 16'h0009, {12'h000, aspectResult, widePlainOut, wideSubtitleOut});
        firstIdBits = 2'h0;
        firstIdValid = 1'b1;
        secondIdBits = 2'h0;
        secondIdValid = 1'b0;
        host.readFrame(8'h39, ack, st);
        check("status aspect", 16'h0006, {8'h00, st});
        $display("Test aspect done");
        // Instant bit: jump now, then the wait applies again
        aspectJudge = 2'h0;
        step(2);
        host.writeFrame(8'h38, 24'h14_4000, 2, acks);
        step(2);
        check("instant jump", 16'h0000, {14'h0000, aspectResult});
        aspectJudge = 2'h1;
        step(10);
        check("wait resumed", 16'h0000, {14'h0000, aspectResult});
        step(WAITN + 5);
        check("wide again", 16'h0001, {14'h0000, aspectResult});
        // Rise while judgement agrees, then drop: no-wait must end
        host.writeFrame(8'h38, 24'h14_0000, 2, acks);
        host.writeFrame(8'h38, 24'h14_4000, 2, acks);
        host.writeFrame(8'h38, 24'h14_0000, 2, acks);
        aspectJudge = 2'h2;
        step(10);
        check("no-wait dropped", 16'h0001, {14'h0000, aspectResult});
        // Aspect reset bit forces 4:3 before the wait ends
        host.writeFrame(8'h38, 24'h14_8000, 2, acks);
        check("aspect reset", 16'h0000, {14'h0000, aspectResult});
        $display("Test instant done");
        // Mid-run reset clears settings, aspect output and pins
        firstIdBits = 2'h3;
        reset = 1'b1;
        step(2);
        check("reset state", 16'h0000, {settings[15:8], 1'b0, aspectResult, letterboxOut,
              fullModeOut, secondIdOut, widePlainOut, wideSubtitleOut});
        check("reset low bits", 16'h0000, {8'h00, settings[7:0]});
        $display("Test reset done");
        stop_test();
    end
endmodule
`default_nettype wire
